// >>> core/ubsm_pkg.sv
// constants and types of the spi master engine
//------------------------------------------------------------
//------------------------------------------------------------
package ubsm_pkg;

  localparam int UBSM_CLK_KHZ = 25000;
  localparam int UBSM_SCK_SLOW_KHZ = 2000;
  localparam int UBSM_SCK_FAST_KHZ = 6000;
  // least half period, rounded up so the slave never sees a faster clock
  localparam int UBSM_HALF_SLOW = (UBSM_CLK_KHZ + 2 * UBSM_SCK_SLOW_KHZ - 1) / (2 * UBSM_SCK_SLOW_KHZ);
  localparam int UBSM_HALF_FAST = (UBSM_CLK_KHZ + 2 * UBSM_SCK_FAST_KHZ - 1) / (2 * UBSM_SCK_FAST_KHZ);
  localparam int UBSM_DATA_BITS = 8;
  localparam int UBSM_EDGES = 2 * UBSM_DATA_BITS;
  localparam logic UBSM_SS_IDLE = 1'h1;
  localparam logic UBSM_LATCH_DEFAULT = 1'h1;

  typedef enum logic [1:0] {
    UBSM_DRV_PUSH_PULL,
    UBSM_DRV_OPEN_DRAIN,
    UBSM_DRV_OPEN_DRAIN_PU
  } ubsm_drive_t;

  typedef struct packed {
    logic spi_enable;
    logic four_wire;
    logic fast_rate;
    logic lsb_first;
    logic cpol;
    logic cpha;
  } ubsm_cfg_t;

  typedef struct packed {
    ubsm_drive_t miso;
    ubsm_drive_t sck;
    ubsm_drive_t mosi;
    ubsm_drive_t ss;
  } ubsm_drive_cfg_t;

  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
  } ubsm_pin_t;

endpackage

// >>> core/ubsm_sync.sv
// two flip-flop synchroniser for a pin input
`timescale 1ns/10ps
module ubsm_sync (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic d,
  output logic q
);
  logic meta;
  logic next_meta;
  logic next_q;

  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      meta <= 1'h1;
      q <= 1'h1;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule

// >>> core/ubsm_spi_master.sv
// spi master engine: shifter, clock generator, select and pin takeover
`timescale 1ns/10ps
module ubsm_spi_master
  import ubsm_pkg::*;
#(
  parameter int HALF_SLOW = UBSM_HALF_SLOW,
  parameter int HALF_FAST = UBSM_HALF_FAST
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire ubsm_cfg_t cfg,
  input wire ubsm_drive_cfg_t drive,
  input wire logic start,
  input wire logic [UBSM_DATA_BITS-1:0] tx_data,
  output logic busy,
  output logic done,
  output logic [UBSM_DATA_BITS-1:0] rx_data,
  output logic spi_owns_pins,
  input wire logic port_pin_eight_in,
  output ubsm_pin_t port_pin_eight,
  output ubsm_pin_t port_pin_nine,
  output ubsm_pin_t port_pin_ten,
  output ubsm_pin_t port_pin_five
);

  localparam int CW = $clog2(HALF_SLOW + 1);
  localparam int EW = $clog2(UBSM_EDGES);
  localparam logic [EW-1:0] LAST_EDGE = EW'(UBSM_EDGES - 1);

  typedef enum logic [1:0] {UBSM_IDLE, UBSM_SHIFT, UBSM_TRAIL} ubsm_state_t;

  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  function automatic logic out_bit(input logic [UBSM_DATA_BITS-1:0] v, input logic lsb);
    return lsb ? v[0] : v[UBSM_DATA_BITS-1];
  endfunction

  function automatic logic [UBSM_DATA_BITS-1:0] shift_out(input logic [UBSM_DATA_BITS-1:0] v, input logic lsb);
    return lsb ? {1'h0, v[UBSM_DATA_BITS-1:1]} : {v[UBSM_DATA_BITS-2:0], 1'h0};
  endfunction

  function automatic logic [UBSM_DATA_BITS-1:0] shift_in(input logic [UBSM_DATA_BITS-1:0] v, input logic b,
                                                         input logic lsb);
    return lsb ? {b, v[UBSM_DATA_BITS-1:1]} : {v[UBSM_DATA_BITS-2:0], b};
  endfunction

  function automatic logic [CW-1:0] half_load(input logic fast);
    return fast ? CW'(HALF_FAST - 1) : CW'(HALF_SLOW - 1);
  endfunction

  // open-drain pins only pull low; a one is left to the pull-up
  function automatic ubsm_pin_t pin_drive(input logic en, input logic value, input ubsm_drive_t mode);
    ubsm_pin_t p;
    p.out = value;
    p.oe = en && (mode == UBSM_DRV_PUSH_PULL || !value);
    p.pull_up = en && (mode == UBSM_DRV_OPEN_DRAIN_PU);
    return p;
  endfunction

  //------------------------------------------------------------
  // state
  //------------------------------------------------------------
  ubsm_state_t state, next_state;
  ubsm_cfg_t cur, next_cur;
  logic [CW-1:0] cnt, next_cnt;
  logic [EW-1:0] edge_idx, next_edge_idx;
  logic sck, next_sck;
  logic mosi, next_mosi;
  logic ss, next_ss;
  logic [UBSM_DATA_BITS-1:0] tx_sh, next_tx_sh;
  logic [UBSM_DATA_BITS-1:0] rx_sh, next_rx_sh;
  logic [UBSM_DATA_BITS-1:0] next_rx_data;
  logic next_done;
  logic miso_s;
  logic tick;
  logic sample_now;
  logic setup_now;

  ubsm_sync u_miso_sync (
    .clock(clock),
    .rst_b(rst_b),
    .d(port_pin_eight_in),
    .q(miso_s)
  );

  //------------------------------------------------------------
  // sequencer
  //------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cur = cur;
    next_cnt = cnt;
    next_edge_idx = edge_idx;
    next_sck = sck;
    next_mosi = mosi;
    next_ss = ss;
    next_tx_sh = tx_sh;
    next_rx_sh = rx_sh;
    next_rx_data = rx_data;
    next_done = 1'h0;
    tick = (cnt == '0);
    sample_now = 1'h0;
    setup_now = 1'h0;
    unique case (state)
      UBSM_IDLE: begin
        next_sck = cfg.cpol;
        next_ss = UBSM_SS_IDLE;
        // shift settings are frozen per byte; spi_enable and four_wire still act on the pins at once
        if (start && cfg.spi_enable) begin
          next_state = UBSM_SHIFT;
          next_cur = cfg;
          next_cnt = half_load(cfg.fast_rate);
          next_edge_idx = '0;
          next_ss = !cfg.four_wire;
          next_tx_sh = tx_data;
          next_rx_sh = '0;
          if (!cfg.cpha) begin
            next_mosi = out_bit(tx_data, cfg.lsb_first);
            next_tx_sh = shift_out(tx_data, cfg.lsb_first);
          end
        end
      end
      UBSM_SHIFT: begin
        if (tick) begin
          next_cnt = half_load(cur.fast_rate);
          next_sck = !sck;
          next_edge_idx = EW'(edge_idx + 1);
          sample_now = (edge_idx[0] == cur.cpha);
          setup_now = !sample_now && (edge_idx != LAST_EDGE);
          if (sample_now) begin
            next_rx_sh = shift_in(rx_sh, miso_s, cur.lsb_first);
          end
          if (setup_now) begin
            next_mosi = out_bit(tx_sh, cur.lsb_first);
            next_tx_sh = shift_out(tx_sh, cur.lsb_first);
          end
          if (edge_idx == LAST_EDGE) begin
            next_state = UBSM_TRAIL;
          end
        end else begin
          next_cnt = CW'(cnt - 1);
        end
      end
      UBSM_TRAIL: begin
        if (tick) begin
          next_state = UBSM_IDLE;
          next_ss = UBSM_SS_IDLE;
          next_mosi = UBSM_LATCH_DEFAULT;
          next_done = 1'h1;
          next_rx_data = rx_sh;
        end else begin
          next_cnt = CW'(cnt - 1);
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state <= UBSM_IDLE;
      cur <= '0;
      cnt <= '0;
      edge_idx <= '0;
      sck <= 1'h0;
      mosi <= UBSM_LATCH_DEFAULT;
      ss <= UBSM_SS_IDLE;
      tx_sh <= '0;
      rx_sh <= '0;
      rx_data <= '0;
      done <= 1'h0;
    end else begin
      state <= next_state;
      cur <= next_cur;
      cnt <= next_cnt;
      edge_idx <= next_edge_idx;
      sck <= next_sck;
      mosi <= next_mosi;
      ss <= next_ss;
      tx_sh <= next_tx_sh;
      rx_sh <= next_rx_sh;
      rx_data <= next_rx_data;
      done <= next_done;
    end
  end

  //------------------------------------------------------------
  // pin takeover
  //------------------------------------------------------------
  assign busy = (state != UBSM_IDLE);
  assign spi_owns_pins = cfg.spi_enable;
  // data-in pin keeps its latch at one so only the pull-up acts on it when open-drain; push-pull drives it high
  assign port_pin_eight = pin_drive(cfg.spi_enable, UBSM_LATCH_DEFAULT, drive.miso);
  assign port_pin_nine = pin_drive(cfg.spi_enable, sck, drive.sck);
  assign port_pin_ten = pin_drive(cfg.spi_enable, mosi, drive.mosi);
  assign port_pin_five = pin_drive(cfg.spi_enable && cfg.four_wire, ss, drive.ss);

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  logic [4:0] ast_edges;
  logic ast_sck_d;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ast_edges <= '0;
      ast_sck_d <= 1'h0;
    end else begin
      ast_sck_d <= sck;
      if (state == UBSM_IDLE) begin
        ast_edges <= '0;
      end else if (sck != ast_sck_d) begin
        ast_edges <= 5'(ast_edges + 1);
      end
    end
  end

  default clocking ast_clk @(posedge clock); endclocking
  default disable iff (!rst_b);

  // reset loads a constant clock level, so the first idle cycle after release is left out
  AST_IDLE_SCK: assert property ((!busy && $past(!busy) && $past(rst_b)) |-> sck == $past(cfg.cpol))
    else $error("idle clock not at polarity level");
  AST_IDLE_SS: assert property (!busy |-> ss)
    else $error("select low while idle");
  AST_SS_LEAD: assert property ((busy && cur.four_wire && $changed(sck)) |-> (!ss && $past(!ss)))
    else $error("clock edge without select low");
  AST_EDGE_COUNT: assert property (done |-> ast_edges == 5'h10)
    else $error("byte did not have sixteen clock edges");
  AST_HALF_SLOW: assert property ((busy && !cur.fast_rate && $changed(sck)) |=> $stable(sck)[*6])
    else $error("slow half period too short");
  AST_HALF_FAST: assert property ((busy && cur.fast_rate && $changed(sck)) |=> $stable(sck)[*2])
    else $error("fast half period too short");
  AST_SAMPLE_EDGE: assert property (sample_now |-> next_sck == (cur.cpol ~^ cur.cpha))
    else $error("sample on wrong clock edge");
  AST_RX_CAPTURE: assert property (sample_now |=>
      ((cur.lsb_first ? rx_sh[UBSM_DATA_BITS-1] : rx_sh[0]) == $past(miso_s)))
    else $error("input bit not captured");
  AST_MOSI_FIRST: assert property ((!busy && start && cfg.spi_enable && !cfg.cpha) |=>
      (mosi == (cur.lsb_first ? $past(tx_data[0]) : $past(tx_data[UBSM_DATA_BITS-1]))))
    else $error("wrong first output bit");
  AST_PIN_OD: assert property ((cfg.spi_enable && drive.sck != UBSM_DRV_PUSH_PULL) |->
      (port_pin_nine.oe == !sck))
    else $error("open-drain clock pin driven high");
  AST_PIN_TAKEN: assert property ((!cfg.spi_enable || !cfg.four_wire) |-> !port_pin_five.oe)
    else $error("select pin driven when not owned");

  COV_MODE0: cover property (done && !cur.cpol && !cur.cpha);
  COV_MODE3_FAST: cover property (done && cur.cpol && cur.cpha && cur.fast_rate);
  COV_LSB_4WIRE: cover property (done && cur.lsb_first && cur.four_wire);

endmodule

// >>> verification/ubsm_slave_model.sv
// behavioural spi slave on the far side of the master engine
`timescale 1ns/10ps
module ubsm_slave_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_b,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsb,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  int ti;
  int ri;
  function automatic logic pick(int i);
    return lsb ? tx_byte[i] : tx_byte[7-i];
  endfunction
  task automatic setup_bit();
    if (ti < 8) miso = pick(ti);
    ti++;
  endtask
  task automatic sample_bit();
    if (ri < 8) rx_byte[lsb ? ri : 7-ri] = mosi;
    ri++;
  endtask
  initial begin
    miso = 1'h0;
    rx_byte = 8'h00;
    ti = 0;
    ri = 0;
  end
  always @(negedge sel_b) begin
    ti = 0;
    ri = 0;
    if (!cpha) setup_bit();
  end
  // released line floats to the pull-up level
  always @(posedge sel_b) miso = 1'h1;
  always @(posedge sck) begin
    if (!sel_b) begin
      if (cpol == cpha) sample_bit();
      else setup_bit();
    end
  end
  always @(negedge sck) begin
    if (!sel_b) begin
      if (cpol != cpha) sample_bit();
      else setup_bit();
    end
  end
endmodule

// >>> verification/usb_bridge_spi_master_tb_top.sv
// self-checking bench of the spi master engine
`timescale 1ns/10ps
module usb_bridge_spi_master_tb_top import ubsm_pkg::*;;
  localparam int HS = 7;
  localparam int HF = 3;
  logic clock;
  logic rst_b;
  ubsm_cfg_t cfg;
  ubsm_drive_cfg_t drive;
  logic start;
  logic [7:0] tx_data;
  logic busy;
  logic done;
  logic [7:0] rx_data;
  logic owns;
  logic miso;
  logic sel3_b;
  logic [7:0] stx;
  logic [7:0] srx;
  ubsm_pin_t p8;
  ubsm_pin_t p9;
  ubsm_pin_t p10;
  ubsm_pin_t p5;
  int error_cnt;
  int n_tests;
  wire logic sel_b = cfg.four_wire ? p5.out : sel3_b;

  ubsm_spi_master #(.HALF_SLOW(HS), .HALF_FAST(HF)) i_dut (.clock(clock), .rst_b(rst_b), .cfg(cfg),
    .drive(drive), .start(start), .tx_data(tx_data), .busy(busy), .done(done), .rx_data(rx_data),
    .spi_owns_pins(owns), .port_pin_eight_in(miso), .port_pin_eight(p8), .port_pin_nine(p9),
    .port_pin_ten(p10), .port_pin_five(p5));
  ubsm_slave_model i_slave (.sck(p9.out), .mosi(p10.out), .sel_b(sel_b), .cpol(cfg.cpol), .cpha(cfg.cpha),
    .lsb(cfg.lsb_first), .tx_byte(stx), .miso(miso), .rx_byte(srx));

  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tick();
    @(posedge clock);
    #2;
  endtask

  task automatic xfer(input logic [7:0] tx, input logic [7:0] sb);
    int h;
    int f;
    int l;
    int ne;
    logic ps;
    h = cfg.fast_rate ? HF : HS;
    f = -1;
    l = 0;
    ne = 0;
    stx = sb;
    sel3_b = 1'h0;
    tick();
    start = 1'h1;
    tx_data = tx;
    tick();
    start = 1'h0;
    ps = p9.out;
    for (int i = 0; i < 200 && done !== 1'h1; i++) begin
      @(posedge clock);
      #1;
      if (p9.out !== ps) begin
        if (f < 0) f = i;
        l = i;
        ne++;
        if (cfg.four_wire) chk(p5.out, 8'h00, "select high at clock edge");
      end
      ps = p9.out;
    end
    chk(done, 8'h01, "no done");
    chk(rx_data, sb, "received byte");
    chk(srx, tx, "sent byte");
    chk(8'(ne), 8'h10, "clock edge count");
    chk(8'(l - f), 8'(15 * h), "clock rate");
    if (cfg.four_wire) chk(p5.out, 8'h01, "select not released");
    else chk(p5.oe, 8'h00, "select driven in 3-wire");
    tick();
    chk(p9.out, cfg.cpol, "idle clock level");
    sel3_b = 1'h1;
  endtask

  initial begin
    error_cnt = 0;
    n_tests = 0;
    start = 1'h0;
    tx_data = 8'h00;
    sel3_b = 1'h1;
    stx = 8'h00;
    cfg = 6'h00;
    // data input open-drain with pull-up, outputs push-pull
    drive = 8'h80;
    rst_b = 1'h0;
    repeat (20) @(posedge clock);
    #2;
    rst_b = 1'h1;
    chk(p9.oe, 8'h00, "clock pin driven while off");
    cfg = 6'h30;
    tick();
    chk(owns, 8'h01, "pins not taken");
    chk(p9.oe, 8'h01, "clock pin not driven");
    chk(p8.pull_up, 8'h01, "input pull-up");
    chk(p8.oe, 8'h00, "input pin driven");
    chk(p5.out, 8'h01, "select idle");
    $display("test pins done");
    for (int m = 0; m < 16; m++) begin
      {cfg.fast_rate, cfg.lsb_first, cfg.cpol, cfg.cpha} = m[3:0];
      tick();
      xfer(8'hA5 ^ 8'(m * 7), 8'h3C + 8'(m * 9));
    end
    $display("test modes done");
    cfg.four_wire = 1'h0;
    // clock, data-out and select open-drain from here on
    drive = 8'h95;
    xfer(8'h81, 8'h7E);
    chk(p9.oe, 8'h00, "open-drain clock driven high");
    chk(p10.oe, 8'h00, "open-drain data-out driven high");
    $display("test three wire done");
    cfg.four_wire = 1'h1;
    tick();
    start = 1'h1;
    tx_data = 8'hC3;
    tick();
    start = 1'h0;
    repeat (10) tick();
    rst_b = 1'h0;
    repeat (2) tick();
    rst_b = 1'h1;
    chk(busy, 8'h00, "busy after reset");
    chk(rx_data, 8'h00, "received byte after reset");
    chk(p5.out, 8'h01, "select low after reset");
    chk(p5.oe, 8'h00, "open-drain select driven high");
    chk(p10.out, 8'h01, "data-out not at one after reset");
    xfer(8'h5A, 8'hC6);
    $display("test reset done");
    cfg.spi_enable = 1'h0;
    tick();
    start = 1'h1;
    tick();
    start = 1'h0;
    repeat (4) tick();
    chk(busy, 8'h00, "start taken while off");
    chk(p9.oe, 8'h00, "clock pin driven while off");
    $display("test refused done");
    complete_run();
  end

  // about six times the expected run
  initial begin
    #400000;
    error_cnt++;
    $display("mismatch at %0t: %s", $time, "timeout");
    complete_run();
  end
endmodule
